/* sfidr_defs.vh */
`ifndef SFIDR_DEFS_VH
`define SFIDR_DEFS_VH

// Opcodes.
`define SFIDR_OP_MFR_DEV 8'h90
`define SFIDR_OP_JEDEC_ID 8'h9f
`define SFIDR_OP_WAKE_ID 8'hab
`define SFIDR_OP_DEEP_PD 8'hb9

// Address values that pick the byte order of the 0x90 readout.
`define SFIDR_ADDR_MFR_FIRST 24'h000000
`define SFIDR_ADDR_DEV_FIRST 24'h000001

// Frame bit counts.
`define SFIDR_OPCODE_BITS 6'h08
`define SFIDR_ADDR_END_BITS 6'h20
`define SFIDR_BITCNT_ZERO 6'h00
`define SFIDR_BITCNT_ONE 6'h01
`define SFIDR_TWO_BYTE_BITS 5'h10
`define SFIDR_THREE_BYTE_BITS 5'h18

// Identifier slots of the ROM, and fetch cycles per readout. The first of the four
// fetches picks up the ROM's stale word, which is pushed off the top of the shifter.
`define SFIDR_ROM_MFR 2'h0
`define SFIDR_ROM_DEV 2'h1
`define SFIDR_ROM_MEM 2'h2
`define SFIDR_ROM_STEP 2'h1
`define SFIDR_LOAD_STEPS 3'h4

// Delivered contents.
`define SFIDR_ERASED_BYTE 8'hff
`define SFIDR_STATUS_INIT 8'h00

// Power-up write delay, in microseconds, and reference clock rate, in MHz.
`define SFIDR_PUW_MIN_US 1000
`define SFIDR_PUW_MAX_US 10000
`define SFIDR_CLK_MHZ 250

`endif

/* sfidr_id_rom.v */
`timescale 1ns/1ps
// Identifier bytes, read through a registered output.
module sfidr_id_rom #(
  parameter [7:0] MFR_ID = 8'h5a,
  parameter [7:0] DEV_ID = 8'h05,
  parameter [7:0] MEM_TYPE = 8'h20,
  parameter [7:0] CAPACITY = 8'h10
) (
  // Clock and reset.
  input wire ref_clk,
  input wire sys_rst,
  // Read port.
  input wire [1:0] addr,
  output reg [7:0] data
);

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      data <= 8'h00;
    end else begin
      case (addr)
        2'h0: data <= MFR_ID;
        2'h1: data <= DEV_ID;
        2'h2: data <= MEM_TYPE;
        default: data <= CAPACITY;
      endcase
    end
  end

endmodule

/* sfidr_serial_flash_id.v */
`timescale 1ns/1ps
// Function
// - Opcode 90h with address zero returns manufacturer then device byte, MSB first.
// - Opcode 90h with address one returns device byte before manufacturer byte.
// - Opcode 9Fh returns manufacturer, memory type and capacity bytes.
// - A 9Fh command during erase or program is ignored, cycle undisturbed.
// - Deselecting during output stops identifier bits at once.
// - After deselect the device waits in standby for a new selection.
// - Write-type instructions are ignored for 1 to 10 ms after power-up.
// - Delivered array bytes read FFh and status reads 00h.
// - In deep power-down only the wake and read id command is accepted.
`include "sfidr_defs.vh"
module sfidr_serial_flash_id #(
  parameter [7:0] MFR_ID = 8'h5a, // Arbitrary value.
  parameter [7:0] DEV_ID = 8'h05, // Arbitrary value.
  parameter [7:0] MEM_TYPE = 8'h20, // Arbitrary value.
  parameter [7:0] CAPACITY = 8'h10, // Arbitrary value.
  parameter PUW_CYCLES = (`SFIDR_PUW_MIN_US * `SFIDR_CLK_MHZ)
) (
  // Clock and reset.
  input wire ref_clk,
  input wire sys_rst,
  // Serial link pins.
  input wire chipSelect_n,
  input wire serialClk,
  input wire serial_in_pin,
  output reg serialOut,
  output reg serialOutEn,
  // Device state from the rest of the chip.
  input wire writeCycleBusy,
  // Status towards the rest of the chip.
  output reg deepPowerDown,
  output reg writeInhibit,
  output reg [7:0] statusInit,
  output reg [7:0] arrayInitByte
);

  localparam [3:0] ST_CMD = 4'h1;
  localparam [3:0] ST_ADDR = 4'h2;
  localparam [3:0] ST_OUT = 4'h4;
  localparam [3:0] ST_IGNORE = 4'h8;

  reg [2:0] csSync;
  reg [2:0] clkSync;
  reg [1:0] dinSync;
  reg [3:0] state;
  reg [5:0] bitCnt;
  reg [23:0] shiftIn;
  reg [7:0] opcode;
  reg [23:0] outWord;
  reg [4:0] outLeft;
  reg [1:0] romAddr;
  reg [1:0] next_romAddr;
  reg [2:0] loadStep;
  reg [31:0] puwCount;
  wire [7:0] romData;

  wire selected = ~csSync[2];
  wire riseEdge = clkSync[1] & ~clkSync[2];
  wire fallEdge = ~clkSync[1] & clkSync[2];
  wire [7:0] nextByte = {shiftIn[6:0], dinSync[1]};

  sfidr_id_rom #(
    .MFR_ID(MFR_ID),
    .DEV_ID(DEV_ID),
    .MEM_TYPE(MEM_TYPE),
    .CAPACITY(CAPACITY)
  ) u_rom (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .addr(romAddr),
    .data(romData)
  );

  // Slot order of the identifier fetch. The 9Fh readout skips the device slot; the 90h
  // readout that starts on the device slot wraps back to the maker slot.
  always @* begin
    next_romAddr = romAddr + `SFIDR_ROM_STEP;
    if (opcode == `SFIDR_OP_JEDEC_ID && romAddr == `SFIDR_ROM_MFR) begin
      next_romAddr = `SFIDR_ROM_MEM;
    end else if (opcode == `SFIDR_OP_MFR_DEV && romAddr == `SFIDR_ROM_DEV) begin
      next_romAddr = `SFIDR_ROM_MFR;
    end
  end

  // Pin synchronisers; only the second stage onward feeds logic.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      csSync <= 3'h7;
      clkSync <= 3'h0;
      dinSync <= 2'h0;
    end else begin
      csSync <= {csSync[1:0], chipSelect_n};
      clkSync <= {clkSync[1:0], serialClk};
      dinSync <= {dinSync[0], serial_in_pin};
    end
  end

  // Write-inhibit window after power-up, and delivered contents.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      puwCount <= 32'h0;
      writeInhibit <= 1'b1;
      statusInit <= `SFIDR_STATUS_INIT;
      arrayInitByte <= `SFIDR_ERASED_BYTE;
    end else if (writeInhibit) begin
      // Counts from reset release; writes stay refused until the count ends.
      puwCount <= puwCount + 32'h1;
      if (puwCount >= PUW_CYCLES - 1) begin
        writeInhibit <= 1'b0;
      end
    end
  end

  // Command decode and identifier shifting.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_CMD;
      bitCnt <= 6'h0;
      shiftIn <= 24'h0;
      opcode <= 8'h0;
      outWord <= 24'h0;
      outLeft <= 5'h0;
      romAddr <= 2'h0;
      loadStep <= 3'h0;
      serialOut <= 1'b0;
      serialOutEn <= 1'b0;
      deepPowerDown <= 1'b0;
    end else if (!selected) begin
      // Deselect ends any frame, cut or whole, and returns to standby.
      // Deep power-down is entered only when the frame held exactly the B9h opcode.
      if (state == ST_CMD && bitCnt == `SFIDR_OPCODE_BITS && opcode == `SFIDR_OP_DEEP_PD
          && !writeCycleBusy) begin
        deepPowerDown <= 1'b1;
      end
      state <= ST_CMD;
      bitCnt <= 6'h0;
      outLeft <= 5'h0;
      loadStep <= 3'h0;
      serialOutEn <= 1'b0;
    end else begin
      // Fetch the identifier bytes from the ROM, one per cycle. The ROM answers one
      // cycle late, so the first byte shifted in is stale and falls off the top.
      if (loadStep != 3'h0) begin
        loadStep <= loadStep - 3'h1;
        outWord <= {outWord[15:0], romData};
        romAddr <= next_romAddr;
      end
      case (state)
        ST_CMD: begin
          if (riseEdge) begin
            shiftIn <= {shiftIn[22:0], dinSync[1]};
            bitCnt <= bitCnt + `SFIDR_BITCNT_ONE;
            // The opcode is decoded on its eighth rising edge.
            if (bitCnt == `SFIDR_OPCODE_BITS - 6'h1) begin
              opcode <= nextByte;
              if (deepPowerDown && nextByte != `SFIDR_OP_WAKE_ID) begin
                state <= ST_IGNORE;
              end else if (nextByte == `SFIDR_OP_WAKE_ID) begin
                deepPowerDown <= 1'b0;
                state <= ST_IGNORE;
              end else if (nextByte == `SFIDR_OP_JEDEC_ID) begin
                if (writeCycleBusy) begin
                  state <= ST_IGNORE;
                end else begin
                  romAddr <= `SFIDR_ROM_MFR;
                  loadStep <= `SFIDR_LOAD_STEPS;
                  outLeft <= `SFIDR_THREE_BYTE_BITS;
                  state <= ST_OUT;
                end
              end else if (nextByte == `SFIDR_OP_MFR_DEV) begin
                state <= ST_ADDR;
              end else begin
                state <= ST_CMD;
              end
            end
          end
        end
        ST_ADDR: begin
          if (riseEdge) begin
            shiftIn <= {shiftIn[22:0], dinSync[1]};
            bitCnt <= bitCnt + `SFIDR_BITCNT_ONE;
            if (bitCnt == `SFIDR_ADDR_END_BITS - 6'h1) begin
              // Any address other than one gives the maker-first order.
              if ({shiftIn[22:0], dinSync[1]} == `SFIDR_ADDR_DEV_FIRST) begin
                romAddr <= `SFIDR_ROM_DEV;
              end else begin
                romAddr <= `SFIDR_ROM_MFR;
              end
              loadStep <= `SFIDR_LOAD_STEPS;
              outLeft <= `SFIDR_TWO_BYTE_BITS;
              state <= ST_OUT;
            end
          end
        end
        ST_OUT: begin
          // Bits move on the link's falling edge, once the fetch has filled the shifter.
          if (fallEdge && loadStep == 3'h0) begin
            if (outLeft != 5'h0) begin
              serialOut <= outWord[23];
              outWord <= {outWord[22:0], 1'b0};
              serialOutEn <= 1'b1;
              outLeft <= outLeft - 5'h1;
            end else begin
              // The fall after the last bit releases the pin.
              serialOutEn <= 1'b0;
            end
          end
        end
        ST_IGNORE: begin
          // A refused command keeps the pin released until the host deselects.
          serialOutEn <= 1'b0;
        end
        default: begin
          state <= ST_CMD;
        end
      endcase
    end
  end

endmodule

/* sfidr_asserts.sv */
`timescale 1ns/1ps
module sfidr_asserts #(
  parameter integer PUW_CYCLES = 50
) (
  // Clock and reset.
  input wire ref_clk,
  input wire sys_rst,
  // Link pins.
  input wire chipSelect_n,
  input wire serialClk,
  input wire serial_in_pin,
  input wire serialOut,
  input wire serialOutEn,
  // Chip side.
  input wire writeCycleBusy,
  input wire deepPowerDown,
  input wire writeInhibit,
  input wire [7:0] statusInit,
  input wire [7:0] arrayInitByte
);
  reg [31:0] upCnt;
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      upCnt <= 32'h0;
    else if (upCnt < PUW_CYCLES + 4)
      upCnt <= upCnt + 32'h1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_desel_stop: assert property ($rose(chipSelect_n) |-> ##[1:6] !serialOutEn) else $error("late stop");
  a_idle_quiet: assert property (chipSelect_n [*6] |-> !serialOutEn) else $error("drive idle");
  a_start_sel: assert property ($rose(serialOutEn) |-> !chipSelect_n) else $error("drive unselected");
  a_dpd_mute: assert property ($rose(serialOutEn) |-> !$past(deepPowerDown)) else $error("drive asleep");
  a_dpd_desel: assert property ($rose(deepPowerDown) |-> chipSelect_n) else $error("sleep selected");
  a_shift_low: assert property (serialOutEn && $changed(serialOut) |-> !serialClk) else $error("shift high");
  a_puw_hold: assert property (upCnt < PUW_CYCLES - 1 |-> writeInhibit) else $error("inhibit early");
  a_puw_end: assert property (upCnt > PUW_CYCLES + 2 |-> !writeInhibit) else $error("inhibit late");
  a_status_init: assert property (statusInit == 8'h00 && arrayInitByte == 8'hff) else $error("init bad");
  cover property ($rose(serialOutEn));
  cover property ($rose(deepPowerDown));
  cover property ($fell(serialOutEn) && !chipSelect_n);
endmodule

bind sfidr_serial_flash_id sfidr_asserts #(.PUW_CYCLES(PUW_CYCLES)) u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .chipSelect_n(chipSelect_n), .serialClk(serialClk), .serial_in_pin(serial_in_pin), .serialOut(serialOut),
  .serialOutEn(serialOutEn), .writeCycleBusy(writeCycleBusy), .deepPowerDown(deepPowerDown),
  .writeInhibit(writeInhibit), .statusInit(statusInit), .arrayInitByte(arrayInitByte));

/* sfidr_host_model.sv */
`timescale 1ns/1ps
// Link master in mode 0; its clock stays low between frames.
module sfidr_host_model (
  // Clock.
  input wire ref_clk,
  // Link pins.
  input wire serialOut,
  output reg chipSelect_n,
  output reg serialClk,
  output reg serial_in_pin
);
  initial begin
    chipSelect_n = 1'b1;
    serialClk = 1'b0;
    serial_in_pin = 1'b0;
  end
  // Sends ntx bits MSB first, then samples nrx bits on rising edges.
  task xfer(input [31:0] tx, input integer ntx, input integer nrx, output [23:0] rx);
    integer i;
    begin
      rx = 24'h0;
      @(posedge ref_clk);
      #1 chipSelect_n = 1'b0;
      for (i = 0; i < ntx + nrx; i = i + 1) begin
        serial_in_pin = (i < ntx) ? tx[31 - i] : ~serial_in_pin;
        #62.5 serialClk = 1'b1;
        if (i >= ntx)
          rx = {rx[22:0], serialOut};
        #62.5 serialClk = 1'b0;
      end
      #62.5 chipSelect_n = 1'b1;
      serial_in_pin = ~serial_in_pin;
      #100;
    end
  endtask
endmodule

/* sfidr_tb_top.sv */
`timescale 1ns/1ps
module sfidr_tb_top;
  localparam [7:0] MFR = 8'h5a; // Arbitrary value.
  localparam [7:0] DEV = 8'h05;
  localparam [7:0] MEM = 8'h20;
  localparam [7:0] CAP = 8'h10;
  reg ref_clk, sys_rst, writeCycleBusy;
  reg [23:0] enCycles = 24'h0;
  reg [23:0] enBase;
  wire chipSelect_n, serialClk, serial_in_pin, serialOut, serialOutEn, deepPowerDown, writeInhibit;
  wire [7:0] statusInit, arrayInitByte;
  reg [23:0] rx;
  integer mismatches = 0;
  integer total_checks = 0;
  sfidr_serial_flash_id #(.MFR_ID(MFR), .DEV_ID(DEV), .MEM_TYPE(MEM), .CAPACITY(CAP), .PUW_CYCLES(50)) dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .chipSelect_n(chipSelect_n), .serialClk(serialClk),
    .serial_in_pin(serial_in_pin), .serialOut(serialOut), .serialOutEn(serialOutEn), .writeCycleBusy(writeCycleBusy),
    .deepPowerDown(deepPowerDown), .writeInhibit(writeInhibit), .statusInit(statusInit), .arrayInitByte(arrayInitByte));
  sfidr_host_model host (.ref_clk(ref_clk), .serialOut(serialOutEn ? serialOut : 1'bz),
    .chipSelect_n(chipSelect_n), .serialClk(serialClk), .serial_in_pin(serial_in_pin));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Counts cycles in which the device drives its output pin.
  always @(posedge ref_clk) begin
    if (serialOutEn === 1'b1)
      enCycles <= enCycles + 24'h1;
  end
  task chk(input [23:0] got, input [23:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task end_sim;
    begin
      $display("checks=%0d mismatches=%0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task wt(input integer n);
    begin
      repeat (n) @(posedge ref_clk);
      #1;
    end
  endtask
  task t_init;
    begin
      chk({16'h0, statusInit}, 24'h000000);
      chk({16'h0, arrayInitByte}, 24'h0000ff);
      chk({23'h0, writeInhibit}, 24'h000001);
      wt(60);
      chk({23'h0, writeInhibit}, 24'h000000);
    end
  endtask
  task t_ids;
    begin
      host.xfer(32'h90000000, 32, 16, rx);
      chk(rx, {8'h0, MFR, DEV});
      host.xfer(32'h90000001, 32, 16, rx);
      chk(rx, {8'h0, DEV, MFR});
      host.xfer(32'h9f000000, 8, 24, rx);
      chk(rx, {MFR, MEM, CAP});
      host.xfer(32'h9f000000, 8, 5, rx);
      chk(rx, {19'h0, MFR[7:3]});
      chk({23'h0, serialOutEn}, 24'h000000);
      host.xfer(32'h9f000000, 8, 24, rx);
      chk(rx, {MFR, MEM, CAP});
    end
  endtask
  task t_refuse;
    begin
      wt(1);
      writeCycleBusy = 1'b1;
      enBase = enCycles;
      host.xfer(32'h9f000000, 8, 24, rx);
      chk(enCycles - enBase, 24'h000000);
      wt(1);
      writeCycleBusy = 1'b0;
      host.xfer(32'hb9000000, 8, 0, rx);
      chk({23'h0, deepPowerDown}, 24'h000001);
      wt(1);
      enBase = enCycles;
      host.xfer(32'h90000000, 32, 16, rx);
      chk(enCycles - enBase, 24'h000000);
      host.xfer(32'hab000000, 8, 0, rx);
      chk({23'h0, deepPowerDown}, 24'h000000);
      host.xfer(32'h9f000000, 8, 24, rx);
      chk(rx, {MFR, MEM, CAP});
    end
  endtask
  initial begin
    sys_rst = 1'b1;
    writeCycleBusy = 1'b0;
    wt(3);
    sys_rst = 1'b0;
    wt(3);
    t_init;
    t_ids;
    t_refuse;
    end_sim;
  end
  initial begin
    #200000;
    mismatches = mismatches + 1;
    end_sim;
  end
endmodule
